// ### inc/irmode_pkg.sv
/*
 * Shared constants and types for the infrared transceiver mode controller.
 * Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package irmode_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20000000;
    localparam int SETUP_NS = 200;
    localparam int HOLD_NS = 200;
    // Least times round up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC);
    localparam logic [7:0] HOLD_CNT = 8'(HOLD_CYC);

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_TXD = 4'h8;
    // Control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_HIGH_BW = 1;
    localparam int CTRL_SHUTDOWN = 2;
    localparam int CTRL_PIN_EN = 3;
    localparam int CTRL_PIN_LVL = 4;
    // Status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_VALID = 1;
    localparam int STAT_HIGH_BW = 2;
    localparam int STAT_RXD = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_HOLD = 2'b10
    } seq_state_t;

    // Pins toward the transceiver
    typedef struct packed {
        logic txd;
        logic shutdown_and_mode_in;
        logic mode_pin_out;
        logic mode_pin_oe_b;
    } xcvr_pins_t;

    // AXI4-Lite request and answer groups
    typedef struct packed {
        logic awvalid;
        logic [3:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [3:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;
endpackage

// ### core/irmode_sync.sv
/*
 * Three-stage synchroniser for one pin input.
 * Assumes the pin is asynchronous to i_clk; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module irmode_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_level
);
    logic [2:0] stage;

    // ****************************************
    // Capture chain
    // ****************************************
    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], i_pin};
        end
    end

    // Accept a new level only when two later stages agree
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            o_level <= stage[2];
        end
    end
endmodule
`default_nettype wire

// ### core/irmode_ctrl.sv
/*
 * Host-side controller that programs the bandwidth mode of an infrared transceiver.
 * Assumes software on AXI4-Lite, a 20 MHz clock, and the transceiver wired to the pins.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Slow mode up to 115.2 kbit/s
// - Shutdown high, txd set, 200 ns setup
// - Hold txd 200 ns after falling edge
// - End high txd hold before pulse limit
// - Float static mode pin when unused
module irmode_ctrl (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire irmode_pkg::axil_req_t I_AXI,
    output irmode_pkg::axil_rsp_t O_AXI,
    input wire logic I_TX_DATA,
    output logic O_RX_DATA,
    input wire logic I_RXD_PIN,
    output irmode_pkg::xcvr_pins_t O_PINS
);
    import irmode_pkg::*;

    seq_state_t state;
    logic [7:0] count;
    logic [31:0] ctrl;
    logic mode_valid;
    logic mode_high;
    logic req_high;
    logic start;
    logic wake;
    logic rxd_sync;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;

    // ****************************************
    // Receive pin synchroniser
    // ****************************************
    irmode_sync u_rxd_sync (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_pin(I_RXD_PIN),
        .o_level(rxd_sync)
    );

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    // Address and data accepted in either order
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (wr_fire) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
        end else begin
            if (I_AXI.awvalid && !aw_got) begin
                aw_got <= 1'b1;
                aw_addr <= I_AXI.awaddr;
            end
            if (I_AXI.wvalid && !w_got) begin
                w_got <= 1'b1;
                w_data <= I_AXI.wdata;
                w_strb <= I_AXI.wstrb;
            end
        end
    end

    assign wr_fire = aw_got && w_got && !O_AXI.bvalid;
    assign O_AXI.awready = !aw_got && !O_AXI.bvalid;
    assign O_AXI.wready = !w_got && !O_AXI.bvalid;

    // Write response, held until bready
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_AXI.bvalid <= 1'b0;
            O_AXI.bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            O_AXI.bvalid <= 1'b1;
            O_AXI.bresp <= (aw_addr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
        end else if (I_AXI.bready) begin
            O_AXI.bvalid <= 1'b0;
        end
    end

    // Control register; start bit self-clears, and is refused while busy
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctrl <= CTRL_RESET;
        end else if (wr_fire && aw_addr == REG_CTRL && w_strb[0]) begin
            ctrl[7:0] <= w_data[7:0];
            ctrl[CTRL_START] <= w_data[CTRL_START] && state == ST_IDLE;
        end else begin
            ctrl[CTRL_START] <= 1'b0;
        end
    end

    assign start = ctrl[CTRL_START];
    // Leaving shutdown also relatches; a bare falling edge would catch txd mid-change
    assign wake = start || (O_PINS.shutdown_and_mode_in && !ctrl[CTRL_SHUTDOWN]);

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    assign O_AXI.arready = !O_AXI.rvalid;

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_AXI.rvalid <= 1'b0;
            O_AXI.rdata <= 32'h0;
            O_AXI.rresp <= RESP_OKAY;
        end else if (I_AXI.arvalid && !O_AXI.rvalid) begin
            O_AXI.rvalid <= 1'b1;
            O_AXI.rresp <= RESP_OKAY;
            unique case (I_AXI.araddr)
                REG_CTRL: O_AXI.rdata <= {24'h0, ctrl[7:1], 1'b0};
                REG_STATUS: O_AXI.rdata <= {28'h0, rxd_sync, mode_high, mode_valid,
                                            state != ST_IDLE};
                REG_TXD: O_AXI.rdata <= {31'h0, O_PINS.txd};
                default: begin
                    O_AXI.rdata <= 32'h0;
                    O_AXI.rresp <= RESP_SLVERR;
                end
            endcase
        end else if (I_AXI.rready) begin
            O_AXI.rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Programming sequence
    // ****************************************
    // Setup then hold counted in cycles; txd hold runs one cycle past the least, so high txd stays short
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state <= ST_IDLE;
            count <= 8'h0;
            req_high <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (wake) begin
                        state <= ST_SETUP;
                        req_high <= start ? ctrl[CTRL_HIGH_BW] : mode_high;
                        count <= SETUP_CNT;
                    end
                end
                ST_SETUP: begin
                    if (count == 8'h1) begin
                        state <= ST_HOLD;
                        count <= HOLD_CNT;
                    end else begin
                        count <= count - 8'h1;
                    end
                end
                ST_HOLD: begin
                    if (count == 8'h1) begin
                        state <= ST_IDLE;
                    end else begin
                        count <= count - 8'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Host copy of the latched mode; nothing valid until first program
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode_valid <= 1'b0;
            mode_high <= 1'b0;
        end else if (state == ST_SETUP && count == 8'h1) begin
            mode_valid <= 1'b1;
            mode_high <= req_high;
        end else if (ctrl[CTRL_PIN_EN]) begin
            mode_valid <= 1'b1;
            mode_high <= ctrl[CTRL_PIN_LVL];
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PINS.shutdown_and_mode_in <= 1'b1;
            O_PINS.txd <= 1'b0;
        end else begin
            O_PINS.shutdown_and_mode_in <= (state == ST_IDLE && !wake) ?
                ctrl[CTRL_SHUTDOWN] : (state != ST_HOLD && !(state == ST_SETUP
                && count == 8'h1));
            if (state == ST_IDLE && !wake) begin
                O_PINS.txd <= I_TX_DATA && !ctrl[CTRL_SHUTDOWN];
            end else if (state == ST_IDLE) begin
                O_PINS.txd <= start ? ctrl[CTRL_HIGH_BW] : mode_high;
            end
        end
    end

    // Mode pin floats unless software enables it outside shutdown
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PINS.mode_pin_out <= 1'b0;
            O_PINS.mode_pin_oe_b <= 1'b1;
        end else begin
            O_PINS.mode_pin_out <= ctrl[CTRL_PIN_LVL];
            O_PINS.mode_pin_oe_b <= !(ctrl[CTRL_PIN_EN] && !ctrl[CTRL_SHUTDOWN]);
        end
    end

    // Receive data masked during shutdown, where the device grounds it
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RX_DATA <= 1'b0;
        end else begin
            O_RX_DATA <= rxd_sync && !O_PINS.shutdown_and_mode_in;
        end
    end
endmodule
`default_nettype wire

// ### test/irdev_model.sv
/* Behavioural model of the transceiver's mode and receive logic.
   Assumes controller pin levels at its inputs; times in ns. */
`timescale 1ns/1ps
`default_nettype none
module irdev_model (
    input wire logic i_txd,
    input wire logic i_sdm,
    input wire logic i_mode_lvl,
    input wire logic i_mode_oe_b,
    input wire logic i_light,
    output logic o_rxd,
    output logic o_mode_valid,
    output logic o_mode_high,
    output logic o_time_bad
);
    // ****************************************
    // Mode latch and pin timing
    // ****************************************
    logic latched = 1'h0;
    logic high = 1'h0;
    realtime t_txd = 0.0;
    realtime t_fall = -1.0e6;
    // Longest light pulse the emitter passes unclipped
    localparam realtime MAX_PULSE_NS = 80000.0;
    initial o_time_bad = 1'h0;
    // Txd may not move too soon after a latching edge
    always @(i_txd) begin
        if ($realtime - t_fall < 200.0) o_time_bad = 1'h1;
        if (!i_txd && $realtime - t_txd > MAX_PULSE_NS) o_time_bad = 1'h1;
        t_txd = $realtime;
    end
    // Falling edge latches txd; set-up time checked first
    always @(negedge i_sdm) begin
        if ($realtime - t_txd < 200.0) o_time_bad = 1'h1;
        high = i_txd;
        latched = 1'h1;
        t_fall = $realtime;
    end
    // No mode before a choice; a driven pin wins while driven
    assign o_mode_valid = latched || !i_mode_oe_b;
    assign o_mode_high = !i_mode_oe_b ? i_mode_lvl : high;
    // Grounded in shutdown, so never floating; either mode hears light
    assign o_rxd = i_sdm ? 1'h0 : i_light;
endmodule
`default_nettype wire

// ### test/irmode_ctrl_chk.sv
/* Port assertions for the mode controller.
   Assumes it is bound to irmode_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module irmode_ctrl_chk (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire irmode_pkg::axil_req_t I_AXI,
    input wire irmode_pkg::axil_rsp_t O_AXI,
    input wire logic I_TX_DATA,
    input wire logic O_RX_DATA,
    input wire logic I_RXD_PIN,
    input wire irmode_pkg::xcvr_pins_t O_PINS
);
    import irmode_pkg::*;
    // ****************************************
    // Pin and bus properties
    // ****************************************
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    sequence latch_s; $fell(O_PINS.shutdown_and_mode_in); endsequence
    sequence held_off_s; O_PINS.shutdown_and_mode_in [*2]; endsequence
    sequence both_taken_s;
        I_AXI.awvalid && O_AXI.awready && I_AXI.wvalid && O_AXI.wready;
    endsequence
    // Four cycles of stable txd before the latching edge
    setup_time_a: assert property (latch_s |-> $stable(O_PINS.txd) &&
        O_PINS.txd == $past(O_PINS.txd, 2) && O_PINS.txd == $past(O_PINS.txd, 3)
        && O_PINS.txd == $past(O_PINS.txd, 4)) else $error("txd set-up short");
    hold_time_a: assert property (latch_s |-> ##1 $stable(O_PINS.txd) [*3])
        else $error("txd hold short");
    rx_ground_a: assert property (held_off_s |-> !O_RX_DATA)
        else $error("receive data not low in shutdown");
    // Six low samples: the fifth still sees the hold level leaving
    txd_follow_a: assert property (!O_PINS.shutdown_and_mode_in [*6] |->
        O_PINS.txd == $past(I_TX_DATA)) else $error("txd not following data");
    write_resp_a: assert property (both_taken_s |-> ##2 O_AXI.bvalid)
        else $error("write answer late");
    resp_drop_a: assert property (O_AXI.bvalid && I_AXI.bready |=> !O_AXI.bvalid)
        else $error("write answer repeated");
    read_resp_a: assert property (I_AXI.arvalid && O_AXI.arready |=> O_AXI.rvalid)
        else $error("read answer late");
    write_block_a: assert property (O_AXI.bvalid |-> !O_AXI.awready && !O_AXI.wready)
        else $error("write taken while answer pending");
endmodule
bind irmode_ctrl irmode_ctrl_chk irmode_ctrl_chk_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_AXI(I_AXI), .O_AXI(O_AXI), .I_TX_DATA(I_TX_DATA), .O_RX_DATA(O_RX_DATA),
    .I_RXD_PIN(I_RXD_PIN), .O_PINS(O_PINS));
`default_nettype wire

// ### test/test_irmode_ctrl.sv
/* Self-checking bench for the mode controller.
   Assumes the device model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module test_irmode_ctrl;
    import irmode_pkg::*;
    // ****************************************
    // Harness
    // ****************************************
    logic I_CLK = 1'h0;
    logic I_RST_B = 1'h0;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    xcvr_pins_t pins;
    logic tx = 1'h0;
    logic light = 1'h0;
    logic rx, rxd_pin, valid, high, tbad, m;
    logic [31:0] d;
    logic [1:0] r;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    irmode_ctrl irmode_ctrl_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_AXI(req), .O_AXI(rsp),
        .I_TX_DATA(tx), .O_RX_DATA(rx), .I_RXD_PIN(rxd_pin), .O_PINS(pins));
    irdev_model irdev_model_i (.i_txd(pins.txd), .i_sdm(pins.shutdown_and_mode_in),
        .i_mode_lvl(pins.mode_pin_out), .i_mode_oe_b(pins.mode_pin_oe_b), .i_light(light),
        .o_rxd(rxd_pin), .o_mode_valid(valid), .o_mode_high(high), .o_time_bad(tbad));
    initial begin
        forever #25 I_CLK = ~I_CLK;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge I_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic [31:0] cw(input logic st, hb, sd, pe, pl);
        return {27'h0, pl, pe, sd, hb, st};
    endfunction
    // Bus cycles: hold each channel until its own handshake edge
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] e);
        @(posedge I_CLK);
        req.awvalid <= 1'h1;
        req.awaddr <= a;
        req.wvalid <= 1'h1;
        req.wdata <= v;
        req.wstrb <= 4'hF;
        req.bready <= 1'h1;
        do begin
            @(posedge I_CLK);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
        end while (!(req.bready && rsp.bvalid));
        e = rsp.bresp;
        req.bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge I_CLK);
        req.arvalid <= 1'h1;
        req.araddr <= a;
        req.rready <= 1'h1;
        do begin
            @(posedge I_CLK);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
        end while (!(req.rready && rsp.rvalid));
        v = rsp.rdata;
        e = rsp.rresp;
        req.rready <= 1'h0;
    endtask
    task automatic idle();
        repeat (20) begin
            rd(REG_STATUS, d, r);
            if (d[STAT_BUSY] === 1'h0) break;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h0587));
        repeat (20) @(posedge I_CLK);
        I_RST_B <= 1'h1;
        light <= 1'h1;
        rd(REG_CTRL, d, r);
        chk("ctrl reset", CTRL_RESET, d);
        chk("mode chosen", 32'h0, 32'(valid));
        chk("rx in shutdown", 32'h0, 32'(rx));
        // Both modes first, then random ones, each with traffic after
        for (int i = 0; i < 8; i++) begin
            m = (i < 2) ? i[0] : 1'($urandom);
            light <= 1'h0;
            wr(REG_CTRL, cw(1'h1, m, 1'h0, 1'h0, 1'h0), r);
            idle();
            chk("latched mode", 32'(m), 32'(high));
            chk("mode chosen", 32'h1, 32'(valid));
            chk("status", {29'h0, m, 2'h2}, d);
            chk("pin timing", 32'h0, 32'(tbad));
            tx <= 1'($urandom);
            light <= 1'($urandom);
            repeat (8) @(posedge I_CLK);
            chk("txd pin", 32'(tx), 32'(pins.txd));
            chk("rx data", 32'(light), 32'(rx));
            rd(REG_TXD, d, r);
            chk("txd reg", 32'(tx), d);
        end
        // A start while busy is dropped, so the first choice stays
        wr(REG_CTRL, cw(1'h1, 1'h1, 1'h0, 1'h0, 1'h0), r);
        wr(REG_CTRL, cw(1'h1, 1'h0, 1'h0, 1'h0, 1'h0), r);
        idle();
        chk("busy start", 32'h1, 32'(high));
        wr(REG_CTRL, cw(1'h0, 1'h0, 1'h1, 1'h0, 1'h0), r);
        light <= 1'h1;
        repeat (8) @(posedge I_CLK);
        chk("rx in shutdown", 32'h0, 32'(rx));
        chk("mode kept", 32'h1, 32'(high));
        // Static pin level against the opposite programmed mode
        for (int k = 0; k < 2; k++) begin
            wr(REG_CTRL, cw(1'h1, !k[0], 1'h0, 1'h1, k[0]), r);
            idle();
            chk("pin driven", 32'h0, 32'(pins.mode_pin_oe_b));
            chk("static mode", 32'(k[0]), 32'(high));
        end
        wr(REG_CTRL, cw(1'h0, 1'h0, 1'h1, 1'h1, 1'h1), r);
        repeat (2) @(posedge I_CLK);
        chk("pin floats", 32'h1, 32'(pins.mode_pin_oe_b));
        wr(REG_STATUS, 32'h0, r);
        chk("status write", 32'(RESP_SLVERR), 32'(r));
        rd(4'hC, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        chk("unmapped data", 32'h0, d);
        chk("pin timing", 32'h0, 32'(tbad));
        finish_test();
    end
endmodule
`default_nettype wire
